// ===== shared/pps_pkg.sv
`default_nettype none
package pps_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CFG   = 8'h00;
  localparam logic [7:0] OFF_ADDR  = 8'h04;
  localparam logic [7:0] OFF_CTRL  = 8'h08;
  localparam logic [7:0] OFF_PSEL  = 8'h0C;
  localparam logic [7:0] OFF_PDATA = 8'h10;
  localparam logic [7:0] OFF_STAT  = 8'h14;

  localparam int CFG_DIR_BIT  = 0;
  localparam int CFG_MOT_BIT  = 1;
  localparam int CFG_LOCK_BIT = 2;
  localparam int CFG_BEEP_BIT = 3;
  localparam int CFG_COMM_LSB = 4;
  localparam int CFG_BAUD_LSB = 8;

  localparam int CTL_START_BIT  = 0;
  localparam int CTL_STOP_BIT   = 1;
  localparam int CTL_SYSRST_BIT = 2;

  // ----------------------------------------------------------------
  // phase word layout and function codes
  // ----------------------------------------------------------------
  localparam int PW_FUNC_LSB = 0;
  localparam int PW_DIR_BIT  = 4;
  localparam int PW_ARG_LSB  = 8;
  localparam int PW_RATE_LSB = 16;

  localparam logic [3:0] FN_RATE  = 4'h0;
  localparam logic [3:0] FN_STOP  = 4'h1;
  localparam logic [3:0] FN_JUMP  = 4'h2;
  localparam logic [3:0] FN_PRSEL = 4'h3;

  localparam logic [5:0] PH_FIRST = 6'h01;
  localparam logic [5:0] PH_MAX   = 6'h29;
  localparam int         PH_DEPTH = 41;

  // ----------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------
  localparam logic       DIR_INFUSE   = 1'b0;
  localparam logic       DIR_WITHDRAW = 1'b1;
  localparam logic       DMODE_RECIP  = 1'b0;
  localparam logic       DMODE_DUAL   = 1'b1;
  localparam logic [6:0] ADDR_MAX     = 7'h63;
  localparam logic [6:0] ADDR_RST     = 7'h00;
  localparam logic [1:0] COMM_ADDR    = 2'h0;
  localparam logic [1:0] COMM_REV     = 2'h1;
  localparam logic [1:0] COMM_SAME    = 2'h2;
  localparam logic [2:0] BAUD_300     = 3'h0;
  localparam logic [2:0] BAUD_1200    = 3'h1;
  localparam logic [2:0] BAUD_2400    = 3'h2;
  localparam logic [2:0] BAUD_9600    = 3'h3;
  localparam logic [2:0] BAUD_19200   = 3'h4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int BEEP_SHORT_NS = 50000000;
  localparam int BEEP_CYC      = BEEP_SHORT_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_FETCH, ST_RUN, ST_WSEL, ST_DONE} pps_seq_t;

  typedef struct packed {
    pps_seq_t    seq;
    logic [5:0]  phase;
    logic        dir;
    logic [15:0] rate;
    logic        dir_mode;
    logic        mot_cfg;
    logic        lock_en;
    logic        beep_en;
    logic [1:0]  comm;
    logic [2:0]  baud;
    logic [6:0]  addr;
    logic [5:0]  psel;
    logic [31:0] prdata;
    logic        pslverr;
    logic        chg_ok;
    logic        lock_ind;
    logic        mot;
    logic        beep;
    logic [23:0] beep_cnt;
  } pps_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } pps_sync_t;
endpackage
`default_nettype wire

// ===== core/pps_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pps_sync (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  pps_pkg::pps_sync_t s_q;
  pps_pkg::pps_sync_t s_d;

  always_comb begin
    s_d    = s_q;
    s_d.s1 = pin_in;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
  end

  // reset to idle-high so a released pin does not fake an edge
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // only s2 and s3 are looked at; s1 feeds s2 alone
  assign level_out = s_q.s2;
  assign rise_out  = s_q.s2 & ~s_q.s3;
  assign fall_out  = ~s_q.s2 & s_q.s3;
endmodule
`default_nettype wire

// ===== core/pps_core.sv
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module pps_core #(
  parameter int BEEP_CYC = pps_pkg::BEEP_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        dir_pin_in,
  input  wire logic        prog_pin_in,
  input  wire logic        key_start_in,
  input  wire logic        key_stop_in,
  input  wire logic        key_change_in,
  input  wire logic        key_any_in,
  input  wire logic        sel_go_in,
  input  wire logic        ttl_start_in,
  input  wire logic        ttl_stop_in,
  input  wire logic        motor_moving_in,
  input  wire logic        pause_timer_in,
  input  wire logic        phase_done_in,
  output logic             motor_run_out,
  output logic             beeper_out,
  output logic             locked_indication_out,
  output logic             change_ok_out,
  output logic             running_out,
  output logic             pump_dir_out,
  output logic [15:0]      rate_out,
  output logic [5:0]       phase_out,
  output logic [6:0]       net_addr_out,
  output logic [2:0]       baud_sel_out,
  output logic             sec_active_out,
  output logic             sec_run_out,
  output logic             sec_dir_out,
  output logic [15:0]      sec_rate_out
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pin_raw;
  logic [1:0] pin_lvl;
  logic [1:0] pin_rise;
  logic [1:0] pin_fall;

  assign pin_raw = {prog_pin_in, dir_pin_in};

  for (genvar i = 0; i < 2; i++) begin : g_sync
    pps_sync u_sync (
      .clk_in    (clk_in),
      .rstn_in   (rstn_in),
      .pin_in    (pin_raw[i]),
      .level_out (pin_lvl[i]),
      .rise_out  (pin_rise[i]),
      .fall_out  (pin_fall[i])
    );
  end

  // ----------------------------------------------------------------
  // program store
  // ----------------------------------------------------------------
  pps_pkg::pps_state_t s_q;
  pps_pkg::pps_state_t s_d;
  logic [31:0]         mem [0:pps_pkg::PH_DEPTH-1];
  logic                nv_lock_q;
  logic [31:0]         ph_word;
  logic [31:0]         ph_first;
  logic [31:0]         ph_sel;

  function automatic logic [5:0] sat_phase(input logic [7:0] v);
    if (v > 8'(pps_pkg::PH_MAX)) begin
      sat_phase = pps_pkg::PH_MAX;
    end else if (v == 8'h00) begin
      sat_phase = pps_pkg::PH_FIRST;
    end else begin
      sat_phase = v[5:0];
    end
  endfunction

  assign ph_word  = mem[s_q.phase - 6'h01];
  assign ph_first = mem[0];
  assign ph_sel   = mem[s_q.psel - 6'h01];

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic apb_wr;
  logic apb_setup;
  logic mapped;
  logic ctl_wr;

  assign apb_wr    = psel_in & penable_in & pwrite_in;
  assign apb_setup = psel_in & ~penable_in;
  assign ctl_wr    = apb_wr && (paddr_in == pps_pkg::OFF_CTRL);

  always_comb begin
    if (paddr_in == pps_pkg::OFF_CFG) begin
      mapped = 1'b1;
    end else if (paddr_in == pps_pkg::OFF_ADDR) begin
      mapped = 1'b1;
    end else if (paddr_in == pps_pkg::OFF_CTRL) begin
      mapped = 1'b1;
    end else if (paddr_in == pps_pkg::OFF_PSEL) begin
      mapped = 1'b1;
    end else if (paddr_in == pps_pkg::OFF_PDATA) begin
      mapped = 1'b1;
    end else if (paddr_in == pps_pkg::OFF_STAT) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // no power-on clear: the program and its lockout copy stand for nvram
  always_ff @(posedge clk_in) begin
    if (apb_wr && mapped && paddr_in == pps_pkg::OFF_PDATA) begin
      mem[s_q.psel - 6'h01] <= pwdata_in;
    end
    if (ctl_wr && pwdata_in[pps_pkg::CTL_SYSRST_BIT]) begin
      nv_lock_q <= 1'b0;
    end else if (apb_wr && paddr_in == pps_pkg::OFF_CFG) begin
      nv_lock_q <= pwdata_in[pps_pkg::CFG_LOCK_BIT];
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic start_req;
  logic stop_req;
  logic sysrst_req;
  logic locked;
  logic running;

  assign start_req  = key_start_in | ttl_start_in | (ctl_wr & pwdata_in[pps_pkg::CTL_START_BIT]);
  assign stop_req   = key_stop_in | ttl_stop_in | (ctl_wr & pwdata_in[pps_pkg::CTL_STOP_BIT]);
  assign sysrst_req = ctl_wr & pwdata_in[pps_pkg::CTL_SYSRST_BIT];
  assign locked     = s_q.lock_en & pin_lvl[1];
  assign running    = (s_q.seq == pps_pkg::ST_FETCH) || (s_q.seq == pps_pkg::ST_RUN) ||
                      (s_q.seq == pps_pkg::ST_WSEL);

  always_comb begin
    s_d        = s_q;
    s_d.chg_ok = 1'b0;
    case (s_q.seq)
      pps_pkg::ST_BOOT: begin
        if (nv_lock_q && ph_first[pps_pkg::PW_FUNC_LSB +: 4] == pps_pkg::FN_PRSEL) begin
          s_d.seq   = pps_pkg::ST_FETCH;
          s_d.phase = pps_pkg::PH_FIRST;
        end else begin
          s_d.seq = pps_pkg::ST_IDLE;
        end
      end
      pps_pkg::ST_IDLE, pps_pkg::ST_DONE: begin
        if (start_req) begin
          s_d.seq   = pps_pkg::ST_FETCH;
          s_d.phase = pps_pkg::PH_FIRST;
        end
      end
      pps_pkg::ST_FETCH: begin
        case (ph_word[pps_pkg::PW_FUNC_LSB +: 4])
          pps_pkg::FN_STOP: begin
            s_d.seq = pps_pkg::ST_DONE;
          end
          pps_pkg::FN_JUMP: begin
            s_d.phase = sat_phase({2'b00, ph_word[pps_pkg::PW_ARG_LSB +: 6]});
          end
          pps_pkg::FN_PRSEL: begin
            s_d.seq = pps_pkg::ST_WSEL;
          end
          default: begin
            s_d.rate = ph_word[pps_pkg::PW_RATE_LSB +: 16];
            s_d.dir  = ph_word[pps_pkg::PW_DIR_BIT];
            s_d.seq  = pps_pkg::ST_RUN;
          end
        endcase
      end
      pps_pkg::ST_RUN, pps_pkg::ST_WSEL: begin
        if ((s_q.seq == pps_pkg::ST_RUN && phase_done_in) ||
            (s_q.seq == pps_pkg::ST_WSEL && sel_go_in)) begin
          if (s_q.phase == pps_pkg::PH_MAX) begin
            s_d.seq = pps_pkg::ST_DONE;
          end else begin
            s_d.phase = s_q.phase + 6'h01;
            s_d.seq   = pps_pkg::ST_FETCH;
          end
        end
      end
      default: begin
        s_d.seq = pps_pkg::ST_IDLE;
      end
    endcase
    if (stop_req && running) begin
      s_d.seq = pps_pkg::ST_IDLE;
    end
    // the pin wins over a phase load in the same cycle
    if (pin_rise[0]) begin
      s_d.dir = (s_q.dir_mode == pps_pkg::DMODE_DUAL) ? pps_pkg::DIR_INFUSE :
                pps_pkg::DIR_WITHDRAW;
    end else if (pin_fall[0]) begin
      s_d.dir = (s_q.dir_mode == pps_pkg::DMODE_DUAL) ? pps_pkg::DIR_WITHDRAW :
                pps_pkg::DIR_INFUSE;
    end
    // keypad edits; serial writes below ignore the lockout
    if (key_change_in) begin
      if (locked) begin
        s_d.lock_ind = 1'b1;
      end else begin
        s_d.chg_ok   = 1'b1;
        s_d.lock_ind = 1'b0;
      end
    end else if (key_any_in) begin
      s_d.lock_ind = 1'b0;
    end
    if (key_any_in && s_q.beep_en) begin
      s_d.beep_cnt = 24'(BEEP_CYC);
    end else if (s_q.beep_cnt != 24'h000000) begin
      s_d.beep_cnt = s_q.beep_cnt - 24'h000001;
    end
    if (apb_wr && paddr_in == pps_pkg::OFF_CFG) begin
      s_d.dir_mode = pwdata_in[pps_pkg::CFG_DIR_BIT];
      s_d.mot_cfg  = pwdata_in[pps_pkg::CFG_MOT_BIT];
      s_d.lock_en  = pwdata_in[pps_pkg::CFG_LOCK_BIT];
      s_d.beep_en  = pwdata_in[pps_pkg::CFG_BEEP_BIT];
      if (pwdata_in[pps_pkg::CFG_COMM_LSB +: 2] <= pps_pkg::COMM_SAME) begin
        s_d.comm = pwdata_in[pps_pkg::CFG_COMM_LSB +: 2];
      end
      if (pwdata_in[pps_pkg::CFG_BAUD_LSB +: 3] <= pps_pkg::BAUD_19200) begin
        s_d.baud = pwdata_in[pps_pkg::CFG_BAUD_LSB +: 3];
      end
    end
    if (apb_wr && paddr_in == pps_pkg::OFF_ADDR && pwdata_in[6:0] <= pps_pkg::ADDR_MAX &&
        pwdata_in[31:7] == 25'h0000000) begin
      s_d.addr = pwdata_in[6:0];
    end
    if (apb_wr && paddr_in == pps_pkg::OFF_PSEL) begin
      s_d.psel = sat_phase((pwdata_in[31:8] != 24'h000000) ? 8'hFF : pwdata_in[7:0]);
    end
    if (sysrst_req) begin
      s_d.lock_en = 1'b0;
      s_d.seq     = pps_pkg::ST_IDLE;
    end
    s_d.mot  = running & (motor_moving_in | (s_q.mot_cfg & pause_timer_in));
    s_d.beep = s_q.beep_en & ((s_q.seq == pps_pkg::ST_DONE) || (s_q.seq == pps_pkg::ST_WSEL) ||
               (s_q.beep_cnt != 24'h000000));
    if (apb_setup) begin
      s_d.pslverr = ~mapped;
      if (paddr_in == pps_pkg::OFF_CFG) begin
        s_d.prdata = {21'h000000, s_q.baud, 2'b00, s_q.comm,
                      s_q.beep_en, s_q.lock_en, s_q.mot_cfg, s_q.dir_mode};
      end else if (paddr_in == pps_pkg::OFF_ADDR) begin
        s_d.prdata = {25'h0000000, s_q.addr};
      end else if (paddr_in == pps_pkg::OFF_PSEL) begin
        s_d.prdata = {26'h0000000, s_q.psel};
      end else if (paddr_in == pps_pkg::OFF_PDATA) begin
        s_d.prdata = ph_sel;
      end else if (paddr_in == pps_pkg::OFF_STAT) begin
        s_d.prdata = {19'h00000, ~pin_lvl[1], locked, s_q.dir, s_q.phase, 1'b0, s_q.seq};
      end else begin
        s_d.prdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= '{seq: pps_pkg::ST_BOOT, phase: pps_pkg::PH_FIRST, dir: pps_pkg::DIR_INFUSE,
               dir_mode: pps_pkg::DMODE_RECIP, comm: pps_pkg::COMM_ADDR,
               baud: pps_pkg::BAUD_19200, addr: pps_pkg::ADDR_RST,
               psel: pps_pkg::PH_FIRST, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata_out            = s_q.prdata;
  assign pready_out            = 1'b1;
  assign pslverr_out           = s_q.pslverr;
  assign motor_run_out         = s_q.mot;
  assign beeper_out            = s_q.beep;
  assign locked_indication_out = s_q.lock_ind;
  assign change_ok_out         = s_q.chg_ok;
  assign running_out           = running;
  assign pump_dir_out          = s_q.dir;
  assign rate_out              = s_q.rate;
  assign phase_out             = s_q.phase;
  assign net_addr_out          = s_q.addr;
  assign baud_sel_out          = s_q.baud;
  assign sec_active_out        = (s_q.comm != pps_pkg::COMM_ADDR);
  assign sec_run_out           = sec_active_out & running;
  assign sec_dir_out           = (s_q.comm == pps_pkg::COMM_REV) ? ~s_q.dir : s_q.dir;
  assign sec_rate_out          = sec_active_out ? s_q.rate : 16'h0000;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  AST_DIR_RECIP: assert property (pin_rise[0] && s_q.dir_mode == pps_pkg::DMODE_RECIP
    |=> pump_dir_out == pps_pkg::DIR_WITHDRAW) else $error("recip rise not withdraw");
  AST_DIR_DUAL: assert property (pin_fall[0] && s_q.dir_mode == pps_pkg::DMODE_DUAL
    |=> pump_dir_out == pps_pkg::DIR_WITHDRAW) else $error("dual fall not withdraw");
  AST_MOT_CFG0: assert property (!s_q.mot_cfg && !motor_moving_in
    |=> !motor_run_out) else $error("motor out high while not moving");
  AST_MOT_CFG1: assert property (s_q.mot_cfg && pause_timer_in && running
    |=> motor_run_out) else $error("motor out low during pause");
  AST_LOCK_REJ: assert property (key_change_in && locked
    |=> locked_indication_out && !change_ok_out) else $error("locked change not rejected");
  AST_KEY_OK: assert property (key_change_in && !pin_lvl[1]
    |=> change_ok_out) else $error("change refused with key present");
  AST_START_P1: assert property (start_req && !running && !sysrst_req &&
    s_q.seq != pps_pkg::ST_BOOT |=> phase_out == pps_pkg::PH_FIRST && running_out)
    else $error("start not at phase 1");
  AST_NEXT: assert property (s_q.seq == pps_pkg::ST_RUN && phase_done_in && !stop_req &&
    !sysrst_req && s_q.phase != pps_pkg::PH_MAX |=> phase_out == $past(s_q.phase) + 6'h01)
    else $error("phase did not advance");
  AST_OVER: assert property (s_q.seq == pps_pkg::ST_RUN && phase_done_in && !stop_req &&
    !sysrst_req && s_q.phase == pps_pkg::PH_MAX |=> !running_out ##1 !motor_run_out)
    else $error("no stop past last phase");
  AST_SAT: assert property (s_q.psel >= pps_pkg::PH_FIRST && s_q.psel <= pps_pkg::PH_MAX)
    else $error("phase select out of range");
  AST_ADDR: assert property (net_addr_out <= pps_pkg::ADDR_MAX)
    else $error("address above 99");
  AST_SYSRST: assert property (sysrst_req |=> !s_q.lock_en && !running_out)
    else $error("system reset kept lockout");
  AST_BEEP: assert property (s_q.beep_en && s_q.seq == pps_pkg::ST_DONE &&
    $stable(s_q.beep_en) |=> beeper_out) else $error("no beep at program end");
  AST_SEC_REV: assert property (s_q.comm == pps_pkg::COMM_REV
    |-> sec_dir_out != pump_dir_out) else $error("secondary direction not reversed");

  COV_JUMP: cover property (s_q.seq == pps_pkg::ST_FETCH &&
    ph_word[pps_pkg::PW_FUNC_LSB +: 4] == pps_pkg::FN_JUMP);
  COV_OVER: cover property (s_q.seq == pps_pkg::ST_RUN && phase_done_in &&
    s_q.phase == pps_pkg::PH_MAX);
  COV_LOCK: cover property (key_change_in && locked);
  COV_AUTO: cover property (s_q.seq == pps_pkg::ST_BOOT ##1 s_q.seq == pps_pkg::ST_FETCH);
endmodule
`default_nettype wire

// ===== sim/pps_ttl_model.sv
`timescale 1ns/10ps
`default_nettype none
module pps_ttl_model (
  input  wire logic dir_cmd_in,
  input  wire logic key_in,
  output logic      dir_pin_out,
  output logic      prog_pin_out
);
  // ----------------------------------------------------------------
  // connector pins
  // ----------------------------------------------------------------
  // skewed so pin edges never line up with the core clock
  assign #1.3 dir_pin_out = dir_cmd_in;
  // key straps the program pin to ground, otherwise pulled up
  assign prog_pin_out = key_in ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ===== sim/test_pump_io_config_and_phase_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module test_pump_io_config_and_phase_sequencer;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk_in, rstn_in, psel, penable, pwrite, kchg, moving, pause;
  logic        done_p, dir_cmd, key_cmd, pstb, pready_out, pslverr_out, serr;
  logic        motor_run_out, beeper_out, lock_out, chg_out, running_out, pdir;
  logic        dir_pin, prog_pin;
  logic        kstop, sel, sec_act, sec_run, sec_dir;
  logic [6:0]  net_addr;
  logic [2:0]  baud;
  logic [7:0]  paddr;
  logic [15:0] rate_out, sec_rate;
  logic [5:0]  phase_out;
  logic [31:0] pwdata, q, pv, e, prdata_out;
  logic [31:0] w [1:41];
  logic [31:0] exp_q [$];
  string       nm_q [$];
  string       nm;
  int          n_fail, checked, seed;
  pps_core #(.BEEP_CYC(8)) pps_core_i (.clk_in(clk_in), .rstn_in(rstn_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .dir_pin_in(dir_pin), .prog_pin_in(prog_pin),
    .key_start_in(1'b0), .key_stop_in(kstop), .key_change_in(kchg), .key_any_in(kchg),
    .sel_go_in(sel), .ttl_start_in(1'b0), .ttl_stop_in(1'b0),
    .motor_moving_in(moving), .pause_timer_in(pause), .phase_done_in(done_p),
    .motor_run_out(motor_run_out), .beeper_out(beeper_out),
    .locked_indication_out(lock_out), .change_ok_out(chg_out),
    .running_out(running_out), .pump_dir_out(pdir), .rate_out(rate_out),
    .phase_out(phase_out), .net_addr_out(net_addr), .baud_sel_out(baud),
    .sec_active_out(sec_act), .sec_run_out(sec_run), .sec_dir_out(sec_dir),
    .sec_rate_out(sec_rate));
  pps_ttl_model pps_ttl_model_i (.dir_cmd_in(dir_cmd), .key_in(key_cmd),
    .dir_pin_out(dir_pin), .prog_pin_out(prog_pin));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // ----------------------------------------------------------------
  // scoreboard: oldest note against each observed result
  // ----------------------------------------------------------------
  always @(posedge clk_in) if (pstb === 1'b1) begin
    e = exp_q.pop_front();
    nm = nm_q.pop_front();
    checked++;
    if (pv !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, pv);
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    exp_q.push_back(x);
    nm_q.push_back(s);
    pv <= g;
    pstb <= 1'b1;
    @(posedge clk_in);
    pstb <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (pready_out !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_fail++;
      print_verdict();
    end
    q = prdata_out;
    serr = pslverr_out;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn_in, psel, penable, pwrite, kchg, moving, pause, done_p, pstb, key_cmd} = '0;
    {kstop, sel} = '0;
    {paddr, pwdata, pv} = '0;
    dir_cmd = 1'b1;
    n_fail = 0;
    checked = 0;
    seed = 66;
    cyc(8);
    rstn_in <= 1'b1;
    cyc(2);
    apb(0, 8'h00, 0); chk("cfg", 32'h0000_0400, q);
    apb(0, 8'h18, 0); chk("unmapped", 32'h0000_0001, {q[30:0], serr});
    apb(1, 8'h04, 32'h63); apb(1, 8'h04, 32'h64);
    apb(0, 8'h04, 0); chk("addr", 32'h0000_0063, q);
    apb(1, 8'h0C, 32'h32); apb(0, 8'h0C, 0); chk("psel", 32'h0000_0029, q);
    // last phase is the top phase, so no closing stop is needed
    for (int p = 1; p <= 41; p++) begin
      w[p] = (p == 2) ? 32'h0000_0402 : ($random(seed) << 16) | ($random(seed) & 32'h10);
      apb(1, 8'h0C, p);
      apb(1, 8'h10, w[p]);
    end
    apb(1, 8'h00, 32'h408);
    apb(1, 8'h08, 32'h4);
    apb(1, 8'h08, 32'h1);
    cyc(2);
    chk("phase", 32'h1, phase_out);
    chk("rate", w[1][31:16], rate_out);
    done_p <= 1'b1; cyc(1); done_p <= 1'b0; cyc(4);
    chk("jump", 32'h4, phase_out);
    pause <= 1'b1; cyc(3); chk("motor0", 32'h0, motor_run_out);
    moving <= 1'b1;
    cyc(2);
    chk("moving", 32'h1, motor_run_out);
    moving <= 1'b0;
    apb(1, 8'h00, 32'h40A); cyc(2); chk("motor1", 32'h1, motor_run_out);
    for (int m = 0; m < 2; m++) begin
      apb(1, 8'h00, 32'h408 | m);
      dir_cmd <= 1'b0; cyc(8); chk("dir fall", m, pdir);
      dir_cmd <= 1'b1; cyc(8); chk("dir rise", !m, pdir);
    end
    repeat (38) begin
      done_p <= 1'b1; cyc(1); done_p <= 1'b0; cyc(3);
    end
    apb(0, 8'h14, 0); chk("end state", 32'h5, q[2:0]);
    chk("beep", 32'h1, beeper_out);
    apb(1, 8'h00, 32'h40C); cyc(4);
    kchg <= 1'b1; cyc(1); kchg <= 1'b0; #1;
    chk("locked", 32'h2, {lock_out, chg_out});
    key_cmd <= 1'b1; cyc(4);
    kchg <= 1'b1; cyc(1); kchg <= 1'b0; #1;
    chk("key ok", 32'h1, {lock_out, chg_out});
    apb(1, 8'h08, 32'h4); apb(0, 8'h00, 0); chk("lock clr", 32'h408, q);
    // phase 1 waits for a selection, so the lockout copy makes power-up run it
    apb(1, 8'h0C, 32'h1);
    apb(1, 8'h10, 32'h3);
    apb(1, 8'h00, 32'h41C);
    rstn_in <= 1'b0;
    cyc(2);
    rstn_in <= 1'b1;
    cyc(3);
    chk("net dflt", 32'h004, {sec_act, net_addr, baud});
    apb(0, 8'h14, 0);
    chk("autorun", 32'h14, q[9:0]);
    // the secondary pump copies the primary rate, so the whole network runs at it
    apb(1, 8'h00, 32'h41C);
    cyc(2);
    chk("sel beep", 32'h1, beeper_out);
    sel <= 1'b1;
    cyc(1);
    sel <= 1'b0;
    cyc(4);
    chk("sec rev", {13'h0000, 2'h3, ~w[4][4], w[4][31:16]},
        {13'h0000, sec_act, sec_run, sec_dir, sec_rate});
    apb(1, 8'h00, 32'h42C);
    chk("sec same", {13'h0000, 2'h3, w[4][4], w[4][31:16]},
        {13'h0000, sec_act, sec_run, sec_dir, sec_rate});
    kstop <= 1'b1;
    cyc(1);
    kstop <= 1'b0;
    cyc(2);
    chk("stop", 32'h4, {sec_act, sec_run, running_out});
    print_verdict();
  end
endmodule
`default_nettype wire
